// ---- adcsq_pkg.sv ----
package adcsq_pkg;
    // Register map (word index on the plain port)
    localparam logic [2:0] ADDR_CTRL0    = 3'h0;
    localparam logic [2:0] ADDR_CTRL1    = 3'h1;
    localparam logic [2:0] ADDR_PIN_EN   = 3'h2;
    localparam logic [2:0] ADDR_RES_LO   = 3'h3;
    localparam logic [2:0] ADDR_RES_HI   = 3'h4;
    localparam logic [2:0] ADDR_IRQ_CTRL = 3'h5;

    // converter_control_0 fields
    localparam int CTRL0_START_BIT = 7;
    localparam int CTRL0_BUSY_BIT  = 6;
    localparam int CTRL0_OFF_BIT   = 5;
    // converter_control_1 fields
    localparam int CTRL1_CHUP_BIT  = 7;
    localparam int CTRL1_REF_BIT   = 3;
    // irq control fields
    localparam int IRQ_GLOBAL_BIT  = 0;
    localparam int IRQ_CONV_BIT    = 1;
    localparam int IRQ_FLAG_BIT    = 2;

    // Reset values
    localparam logic [7:0] CTRL0_RST   = 8'h60;
    localparam logic [7:0] CTRL1_RST   = 8'h00;
    localparam logic [4:0] PIN_EN_RST  = 5'h1f;

    // Conversion timing
    localparam int          CONV_PERIODS = 16;
    localparam logic [2:0]  DIV_UNDEF    = 3'h7;
    localparam int          RES_BITS     = 12;

    typedef struct packed {
        logic [4:0] pin_analog;
        logic [4:0] pull_up_keep;
        logic [4:0] dir_override;
        logic       ref_from_pin;
        logic       power_off;
        logic [3:0] channel;
    } adcsq_front_t;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } adcsq_bus_t;
endpackage : adcsq_pkg

// ---- adcsq_clkdiv.sv ----
`timescale 1ns/10ps
module adcsq_clkdiv (
    input  wire logic       i_sys_clk,
    input  wire logic       i_rstn,
    input  wire logic       i_clear,
    input  wire logic [2:0] i_div_code,
    output logic            o_tick
);
    import adcsq_pkg::*;

    logic [5:0] count;
    logic [5:0] limit;
    logic       wrap;

    // Division ratio 2^code, code 7 gives no ticks
    assign limit = 6'((7'h1 << i_div_code) - 7'h1);
    assign wrap  = (count >= limit);

    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            count  <= 6'h0;
            o_tick <= 1'b0;
        end else if (i_clear || i_div_code == DIV_UNDEF) begin
            count  <= 6'h0;
            o_tick <= 1'b0;
        end else begin
            count  <= wrap ? 6'h0 : 6'(count + 6'h1);
            o_tick <= wrap;
        end
    end
endmodule : adcsq_clkdiv

// ---- adcsq_ctrl.sv ----
`timescale 1ns/10ps
// Notes on behaviour
// R1 - Enabled pin goes analog, other functions off
// R2 - Analog pin drops its pull-up
// R3 - Analog enable overrides port direction
// R4 - Reference select picks pin or supply
// R5 - Power-off bit shuts converter down
// R6 - Software pulses start high then low
// R7 - Busy falls at end, result readable
// R8 - Conversion takes sixteen divided clocks
// R9 - Interrupt needs global and converter enables
// R10 - Result is twelve bits, full scale fff
// R11 - One step is reference over 4096
// R12 - Transitions offset half step, last 1.5
// R13 - Conversion runs on its own
// R14 - Software sets divider, power, channel, pins
// R15 - Channel upper bit and lower three split
// R16 - Divider 1 to 64, code 7 undefined
// R17 - Start held high keeps converter reset
// R18 - End clears busy and sets flag
// R19 - Result split low byte, high nibble
module adcsq_ctrl (
    input  wire logic                      i_sys_clk,
    input  wire logic                      i_rstn,
    input  wire adcsq_pkg::adcsq_bus_t     i_bus,
    output logic [7:0]                     o_rdata,
    output logic                           o_conv_enable,
    output logic [3:0]                     o_conv_channel,
    output logic                           o_sample_strobe,
    input  wire logic [11:0]               i_conv_code,
    output adcsq_pkg::adcsq_front_t        o_front,
    output logic                           o_irq
);
    import adcsq_pkg::*;

    logic [7:0]  ctrl0;
    logic [7:0]  ctrl1;
    logic [4:0]  pin_en;
    logic        irq_global;
    logic        irq_conv;
    logic        irq_flag;
    logic [11:0] result;
    logic        start_q;
    logic        running;
    logic [4:0]  period_cnt;
    logic        tick;
    logic [7:0]  next_rdata;
    logic        wr_ctrl0;
    logic        wr_ctrl1;
    logic        wr_pin;
    logic        wr_irq;
    logic        start_bit;
    logic        start_fall;
    logic        conv_done;
    logic        flag_clear;
    adcsq_front_t next_front;
    logic        read_ok;
    logic        next_busy;
    logic [7:0]  next_ctrl0;
    logic        seq_hold;
    logic        next_running;
    logic        period_step;
    logic [4:0]  next_period;
    logic        next_flag;
    logic        next_irq;
    logic        next_enable;
    logic        next_strobe;

    localparam adcsq_front_t FRONT_RST = '{
        pin_analog:   PIN_EN_RST,
        pull_up_keep: ~PIN_EN_RST,
        dir_override: PIN_EN_RST,
        ref_from_pin: CTRL1_RST[CTRL1_REF_BIT],
        power_off:    CTRL0_RST[CTRL0_OFF_BIT],
        channel:      {CTRL1_RST[CTRL1_CHUP_BIT], CTRL0_RST[2:0]}
    };

    // Write strobe aimed at one register index
    function automatic logic write_hit(input adcsq_bus_t bus,
                                       input logic [2:0] index);
        return bus.wr && bus.addr == {5'h00, index};
    endfunction : write_hit

    assign wr_ctrl0  = write_hit(i_bus, ADDR_CTRL0);
    assign wr_ctrl1  = write_hit(i_bus, ADDR_CTRL1);
    assign wr_pin    = write_hit(i_bus, ADDR_PIN_EN);
    assign wr_irq    = write_hit(i_bus, ADDR_IRQ_CTRL);
    // Reads outside the map return zero
    assign read_ok   = i_bus.rd && i_bus.addr[7:3] == 5'h00;
    assign start_bit = ctrl0[CTRL0_START_BIT];

    // R6 start falling edge
    assign start_fall = start_q && !start_bit;

    // R8 sixteen divided clocks
    assign conv_done  = running && tick && period_cnt == 5'(CONV_PERIODS - 1);
    assign flag_clear = wr_irq && !i_bus.wdata[IRQ_FLAG_BIT];

    // R16 divider from system clock
    adcsq_clkdiv u_div (
        .i_sys_clk  (i_sys_clk),
        .i_rstn     (i_rstn),
        .i_clear    (start_fall),
        .i_div_code (ctrl1[2:0]),
        .o_tick     (tick)
    );

    // R1 analog routing
    assign next_front.pin_analog   = pin_en;
    // R2 pull-up dropped
    assign next_front.pull_up_keep = ~pin_en;
    // R3 direction override
    assign next_front.dir_override = pin_en;
    // R4 reference select
    assign next_front.ref_from_pin = ctrl1[CTRL1_REF_BIT];
    // R5 power off
    assign next_front.power_off    = ctrl0[CTRL0_OFF_BIT];
    // R15 channel split
    assign next_front.channel = {ctrl1[CTRL1_CHUP_BIT], ctrl0[2:0]};

    // R19 result byte split
    always_comb begin
        case (i_bus.addr[2:0])
            ADDR_CTRL0:    next_rdata = ctrl0;
            ADDR_CTRL1:    next_rdata = ctrl1;
            ADDR_PIN_EN:   next_rdata = {3'h0, pin_en};
            ADDR_RES_LO:   next_rdata = result[7:0];
            ADDR_RES_HI:   next_rdata = {4'h0, result[11:8]};
            ADDR_IRQ_CTRL: next_rdata = {5'h0, irq_flag, irq_conv,
                                         irq_global};
            default:       next_rdata = 8'h00;
        endcase
        if (!read_ok) begin
            next_rdata = 8'h00;
        end
    end

    // R17 start high forces busy
    assign next_busy  = (wr_ctrl0 && i_bus.wdata[CTRL0_START_BIT]) ? 1'b1 :
                        conv_done ? 1'b0 : ctrl0[CTRL0_BUSY_BIT];
    // R7 busy bit read-only
    assign next_ctrl0 = wr_ctrl0 ?
                        {i_bus.wdata[7], next_busy, i_bus.wdata[5:0]} :
                        {ctrl0[7], next_busy, ctrl0[5:0]};

    // R17 held in reset
    assign seq_hold     = start_bit || ctrl0[CTRL0_OFF_BIT];
    // R13 autonomous sequencer
    assign next_running = seq_hold   ? 1'b0 :
                          start_fall ? 1'b1 :
                          conv_done  ? 1'b0 : running;
    assign period_step  = running && tick && !conv_done;
    assign next_period  = (seq_hold || start_fall) ? 5'h00 :
                          period_step ? 5'(period_cnt + 5'h01) : period_cnt;

    // R18 flag set wins over clear
    assign next_flag   = conv_done ? 1'b1 : flag_clear ? 1'b0 : irq_flag;
    // R9 gated interrupt
    assign next_irq    = (irq_flag || conv_done) && irq_global && irq_conv;
    // R5 converter power
    assign next_enable = !ctrl0[CTRL0_OFF_BIT];
    assign next_strobe = start_fall && next_enable;

    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            ctrl0 <= CTRL0_RST;
        end else begin
            ctrl0 <= next_ctrl0;
        end
    end

    // R16 divider and reference
    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            ctrl1 <= CTRL1_RST;
        end else if (wr_ctrl1) begin
            ctrl1 <= i_bus.wdata;
        end
    end

    // R1 pin enables
    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            pin_en <= PIN_EN_RST;
        end else if (wr_pin) begin
            pin_en <= i_bus.wdata[4:0];
        end
    end

    // R6 start history
    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            start_q <= 1'b0;
        end else begin
            start_q <= start_bit;
        end
    end

    // R13 running state
    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            running <= 1'b0;
        end else begin
            running <= next_running;
        end
    end

    // R8 period count
    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            period_cnt <= 5'h00;
        end else begin
            period_cnt <= next_period;
        end
    end

    // R9 global enable
    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            irq_global <= 1'b0;
        end else if (wr_irq) begin
            irq_global <= i_bus.wdata[IRQ_GLOBAL_BIT];
        end
    end

    // R9 converter enable
    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            irq_conv <= 1'b0;
        end else if (wr_irq) begin
            irq_conv <= i_bus.wdata[IRQ_CONV_BIT];
        end
    end

    // R18 request flag
    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            irq_flag <= 1'b0;
        end else begin
            irq_flag <= next_flag;
        end
    end

    // R10 R11 R12 twelve-bit code
    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            result <= 12'h000;
        end else if (conv_done) begin
            result <= i_conv_code;
        end
    end

    // R9 interrupt output
    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_irq <= 1'b0;
        end else begin
            o_irq <= next_irq;
        end
    end

    // R7 read data
    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_rdata <= 8'h00;
        end else begin
            o_rdata <= next_rdata;
        end
    end

    // R1 pin routing out
    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_front <= FRONT_RST;
        end else begin
            o_front <= next_front;
        end
    end

    // R5 converter enable out
    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_conv_enable <= !FRONT_RST.power_off;
        end else begin
            o_conv_enable <= next_enable;
        end
    end

    // R15 channel out
    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_conv_channel <= FRONT_RST.channel;
        end else begin
            o_conv_channel <= next_front.channel;
        end
    end

    // R13 sample strobe
    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_sample_strobe <= 1'b0;
        end else begin
            o_sample_strobe <= next_strobe;
        end
    end
endmodule : adcsq_ctrl

// ---- adcsq_ctrl_sva.sv ----
`timescale 1ns/10ps
module adcsq_ctrl_sva (
    input wire logic                  i_sys_clk,
    input wire logic                  i_rstn,
    input wire adcsq_pkg::adcsq_bus_t i_bus,
    input wire logic [7:0]            o_rdata,
    input wire logic                  o_conv_enable,
    input wire logic [3:0]            o_conv_channel,
    input wire logic                  o_sample_strobe,
    input wire adcsq_pkg::adcsq_front_t o_front,
    input wire logic                  o_irq
);
    import adcsq_pkg::*;
    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (!i_rstn);
    pull_drop_a: assert property (
        o_front.pull_up_keep == ~o_front.pin_analog) else $error("pull-up kept");
    dir_override_a: assert property (
        o_front.dir_override == o_front.pin_analog) else $error("dir kept");
    power_map_a: assert property (
        o_conv_enable == !o_front.power_off) else $error("power mismatch");
    channel_map_a: assert property (
        o_conv_channel == o_front.channel) else $error("channel mismatch");
    strobe_pulse_a: assert property (
        o_sample_strobe |=> !o_sample_strobe) else $error("strobe too long");
    strobe_power_a: assert property (
        o_sample_strobe |-> o_conv_enable) else $error("strobe while off");
    rdata_idle_a: assert property (
        !$past(i_bus.rd) |-> o_rdata == 8'h00) else $error("stray read data");
    irq_gate_a: assert property (
        (i_bus.wr && i_bus.addr == 8'(ADDR_IRQ_CTRL) && i_bus.wdata[1:0] != 2'h3)
        |-> ##2 !o_irq) else $error("irq without both enables");
endmodule : adcsq_ctrl_sva

bind adcsq_ctrl adcsq_ctrl_sva chk (.i_sys_clk(i_sys_clk), .i_rstn(i_rstn),
    .i_bus(i_bus), .o_rdata(o_rdata), .o_conv_enable(o_conv_enable),
    .o_conv_channel(o_conv_channel), .o_sample_strobe(o_sample_strobe),
    .o_front(o_front), .o_irq(o_irq));

// ---- testbench.sv ----
`timescale 1ns/10ps
module testbench;
    import adcsq_pkg::*;
    logic         i_sys_clk;
    logic         i_rstn;
    adcsq_bus_t   i_bus;
    logic [7:0]   o_rdata;
    logic         o_conv_enable;
    logic [3:0]   o_conv_channel;
    logic         o_sample_strobe;
    logic [11:0]  i_conv_code;
    adcsq_front_t o_front;
    logic         o_irq;
    logic [7:0]   d;
    int           mismatches = 0;
    int           total_checks = 0;
    int           n;
    int           strobes = 0;

    adcsq_ctrl dut (.i_sys_clk(i_sys_clk), .i_rstn(i_rstn), .i_bus(i_bus),
        .o_rdata(o_rdata), .o_conv_enable(o_conv_enable),
        .o_conv_channel(o_conv_channel),
        .o_sample_strobe(o_sample_strobe), .i_conv_code(i_conv_code),
        .o_front(o_front), .o_irq(o_irq));

    always @(negedge i_sys_clk) begin
        if (o_sample_strobe === 1'b1) begin
            strobes++;
        end
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge i_sys_clk);
        i_bus <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
        @(posedge i_sys_clk);
        i_bus.wr <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a);
        @(posedge i_sys_clk);
        i_bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge i_sys_clk);
        i_bus.rd <= 1'b0;
        #1 d = o_rdata;
    endtask : rd

    task automatic settle();
        repeat (2) @(posedge i_sys_clk);
        #1;
    endtask : settle

    task automatic conv(input logic [2:0] dv, input logic [11:0] c);
        @(posedge i_sys_clk);
        i_conv_code <= c;
        wr(8'(ADDR_CTRL1), {5'h00, dv});
        wr(8'(ADDR_CTRL0), 8'h80);
        wr(8'(ADDR_CTRL0), 8'h00);
        n = 0;
        do begin
            rd(8'(ADDR_CTRL0));
            n += 2;
        end while (d[CTRL0_BUSY_BIT] === 1'b1 && n < 3000);
        check(16'(n >= (CONV_PERIODS << dv) && n <= (CONV_PERIODS << dv) + 8), 1);
        rd(8'(ADDR_RES_LO));
        check(d, c[7:0]);
        rd(8'(ADDR_RES_HI));
        check(d, {4'h0, c[11:8]});
    endtask : conv

    task automatic results();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : results

    initial begin
        i_sys_clk = 1'b0;
        forever #25 i_sys_clk = ~i_sys_clk;
    end

    initial begin
        repeat (20000) @(posedge i_sys_clk);
        mismatches++;
        results();
    end

    initial begin
        i_rstn = 1'b0;
        i_bus = '0;
        i_conv_code = 12'h000;
        repeat (6) @(posedge i_sys_clk);
        i_rstn <= 1'b1;
        rd(8'(ADDR_CTRL0));
        check(d, CTRL0_RST);
        rd(8'(ADDR_PIN_EN));
        check(d, {3'h0, PIN_EN_RST});
        wr(8'h06, 8'hff);
        rd(8'h06);
        check(d, 8'h00);
        wr(8'(ADDR_PIN_EN), 8'h0a);
        wr(8'(ADDR_CTRL1), 8'h88);
        wr(8'(ADDR_CTRL0), 8'h05);
        settle();
        check(o_front.pin_analog, 5'h0a);
        check(o_front.pull_up_keep, 5'h15);
        check(o_front.dir_override, 5'h0a);
        check(o_front.ref_from_pin, 1'b1);
        check(o_conv_channel, 4'hd);
        check(o_front.channel, 4'hd);
        check(o_conv_enable, 1'b1);
        wr(8'(ADDR_CTRL0), 8'h20);
        settle();
        check(o_conv_enable, 1'b0);
        check(o_front.power_off, 1'b1);
        $display("test pins and controls done");
        wr(8'(ADDR_CTRL0), 8'h80);
        repeat (40) @(posedge i_sys_clk);
        rd(8'(ADDR_CTRL0));
        check(d[CTRL0_BUSY_BIT], 1'b1);
        check(16'(strobes), 16'h0000);
        $display("test start held done");
        for (int k = 0; k < 7; k++) begin
            wr(8'(ADDR_IRQ_CTRL), 8'(3 - (k % 3)));
            conv(3'(k), 12'(12'hfff >> k));
            check(o_irq, 16'(k % 3 == 0));
            rd(8'(ADDR_IRQ_CTRL));
            check(d[IRQ_FLAG_BIT], 1'b1);
            check(16'(strobes), 16'(k + 1));
        end
        wr(8'(ADDR_IRQ_CTRL), 8'h03);
        settle();
        check(o_irq, 1'b0);
        $display("test conversions done");
        results();
    end
endmodule : testbench
